// [core/psv_ctrl.sv]
// Panel supply control bits and panel common / frame polarity clock generator
// Overview of operation
// - After reset both panel clock outputs are held low.
// - Enable bit set starts both panel clocks; cleared stops them.
// - Generator sequences turn-on and turn-off of the outputs itself.
// - Generator clock-disable bit gates the generator while it is 1.
// - Counter-reset bit forces the 16-bit counter to zero while 1.
// - High supply level is a 3-bit code, 4.3V to 5.0V.
// - Low supply level codes 0 to 6 map 2.3V up to 3.4V.
// - Output enable bits drive the corresponding supply outputs.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "psv_params.svh"
module psv_ctrl
	import psv_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [5:2]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	output logic                    wb_err_o,
	input  wire logic               slowOscIn,
	output logic                    panelCommonClock,
	output logic                    panelFramePolarity,
	output psv_supply_s             supplyCtrl,
	output psv_booster_s            boosterCtrl
);
	logic [15:0]  divider_ff;
	logic         enable_ff;
	logic         clkDisable_ff;
	logic         cntReset_ff;
	psv_supply_s  supply_ff;
	psv_booster_s booster_ff;
	logic [1:0]   oscSync_ff;
	logic         oscPrev_ff;
	logic [15:0]  count_ff;
	logic         phase_ff;
	psv_state_e   state_ff;
	logic         ack_ff;
	logic [31:0]  rdata_ff;
	psv_state_e   nxt_state;
	wire logic       access    = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire logic       hitDisp   = wb_adr_i == `PSV_OFS_DISPCTL;
	wire logic       hitDiv    = wb_adr_i == `PSV_OFS_VCOMDIV;
	wire logic       hitClk    = wb_adr_i == `PSV_OFS_VCOMCLK;
	wire logic       hitSup    = wb_adr_i == `PSV_OFS_SUPPLY;
	wire logic       hitPwr    = wb_adr_i == `PSV_OFS_BSTPWR;
	wire logic       hitBclk   = wb_adr_i == `PSV_OFS_BSTCLK;
	wire logic       hitStat   = wb_adr_i == `PSV_OFS_STATUS;
	wire logic       mapped    = hitDisp | hitDiv | hitClk | hitSup | hitPwr | hitBclk | hitStat;
	wire logic       wrB0      = access & mapped & wb_we_i & wb_sel_i[0];
	wire logic       wrB1      = access & mapped & wb_we_i & wb_sel_i[1];
	// Slow oscillator rising edge, seen after two-flop synchroniser
	wire logic       slowTick  = oscSync_ff[1] & ~oscPrev_ff;
	wire logic       genTick   = slowTick & ~clkDisable_ff;
	wire logic       atDivider = count_ff == divider_ff;
	wire logic       outRun    = (state_ff != PSV_OFF);
	// Idle generator keeps the counter at zero so the first half period is full
	wire logic       holdCount = cntReset_ff | (state_ff == PSV_OFF);
	logic [31:0] readMux;
	always_comb
	begin
		readMux = 32'h0000_0000;
		if (hitDisp)
			readMux[`PSV_BIT_COMMON_CLOCK_ENABLE] = enable_ff;
		if (hitDiv)
			readMux[15:0] = divider_ff;
		if (hitClk)
		begin
			readMux[`PSV_BIT_CLKDIS] = clkDisable_ff;
			readMux[`PSV_BIT_CNTRST] = cntReset_ff;
		end
		if (hitSup)
			readMux[7:0] = {supply_ff.lowEn, supply_ff.lowLevel,
				supply_ff.highEn, supply_ff.highLevel};
		if (hitPwr)
			readMux[2:0] = {booster_ff.boostOn, booster_ff.regulator_on, booster_ff.economy};
		if (hitBclk)
			readMux[3:0] = {booster_ff.clkSource, booster_ff.clkDivide};
		if (hitStat)
			readMux[17:0] = {outRun, phase_ff, count_ff};
	end
	// Turn-on waits for a tick; turn-off ends a low half at once, a high one at wrap
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			PSV_OFF:
				if (enable_ff && genTick)
					nxt_state = PSV_RUN;
			PSV_RUN:
				if (!enable_ff && (!phase_ff || (genTick && atDivider)))
					nxt_state = PSV_OFF;
				else if (!enable_ff)
					nxt_state = PSV_DRAIN;
			PSV_DRAIN:
				if (enable_ff)
					nxt_state = PSV_RUN;
				else if (!phase_ff || (genTick && atDivider))
					nxt_state = PSV_OFF;
			default:
				nxt_state = PSV_OFF;
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff   <= access;
			rdata_ff <= readMux;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			enable_ff     <= 1'b0;
			divider_ff    <= `PSV_DIV_RST;
			clkDisable_ff <= 1'b0;
			cntReset_ff   <= 1'b0;
			supply_ff     <= '0;
			booster_ff    <= '0;
		end
		else
		begin
			if (wrB0 && hitDisp)
				enable_ff <= wb_dat_i[`PSV_BIT_COMMON_CLOCK_ENABLE];
			if (wrB0 && hitDiv)
				divider_ff[7:0] <= wb_dat_i[7:0];
			if (wrB1 && hitDiv)
				divider_ff[15:8] <= wb_dat_i[15:8];
			if (wrB0 && hitClk)
			begin
				clkDisable_ff <= wb_dat_i[`PSV_BIT_CLKDIS];
				cntReset_ff   <= wb_dat_i[`PSV_BIT_CNTRST];
			end
			if (wrB0 && hitSup)
				supply_ff <= {wb_dat_i[`PSV_BIT_HON], wb_dat_i[`PSV_LSB_HVOL +: 3],
					wb_dat_i[`PSV_BIT_LON], wb_dat_i[`PSV_LSB_LVOL +: 3]};
			if (wrB0 && hitPwr)
			begin
				booster_ff.economy <= wb_dat_i[`PSV_BIT_ECO];
				booster_ff.regulator_on   <= wb_dat_i[`PSV_BIT_REGULATOR_ON];
				booster_ff.boostOn <= wb_dat_i[`PSV_BIT_BOOSTER_ON];
			end
			if (wrB0 && hitBclk)
			begin
				booster_ff.clkSource <= wb_dat_i[`PSV_BIT_BOOSTER_CLOCK_SOURCE];
				booster_ff.clkDivide <= wb_dat_i[`PSV_LSB_BOOSTER_CLOCK_DIVIDE +: 3];
			end
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			oscSync_ff <= `PSV_SYNC_RST;
			oscPrev_ff <= 1'b0;
		end
		else
		begin
			oscSync_ff <= {oscSync_ff[0], slowOscIn};
			oscPrev_ff <= oscSync_ff[1];
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || holdCount)
			count_ff <= `PSV_CNT_ZERO;
		else if (genTick)
			count_ff <= atDivider ? `PSV_CNT_ZERO : count_ff + 16'h0001;
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_ff <= PSV_OFF;
			phase_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (nxt_state == PSV_OFF)
				phase_ff <= 1'b0;
			else if (state_ff == PSV_OFF || (genTick && atDivider))
				phase_ff <= ~phase_ff;
		end
	end
	// Common clock and frame polarity both follow the phase
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			panelCommonClock   <= 1'b0;
			panelFramePolarity <= 1'b0;
		end
		else
		begin
			panelCommonClock   <= phase_ff & (nxt_state != PSV_OFF);
			panelFramePolarity <= phase_ff & (nxt_state != PSV_OFF);
		end
	end
	assign supplyCtrl  = supply_ff;
	assign boosterCtrl = booster_ff;
	assign wb_ack_o    = ack_ff & mapped;
	assign wb_err_o    = ack_ff & ~mapped;
	assign wb_dat_o    = rdata_ff;
endmodule

// [core/psv_params.svh]
// Register offsets, field positions and reset values for panel supply and common clock control
`ifndef PSV_PARAMS_SVH
`define PSV_PARAMS_SVH
`define PSV_OFS_DISPCTL   4'h0
`define PSV_OFS_VCOMDIV   4'h1
`define PSV_OFS_VCOMCLK   4'h2
`define PSV_OFS_SUPPLY    4'h3
`define PSV_OFS_BSTPWR    4'h4
`define PSV_OFS_BSTCLK    4'h5
`define PSV_OFS_STATUS    4'h6
`define PSV_BIT_COMMON_CLOCK_ENABLE    0
`define PSV_BIT_CLKDIS    0
`define PSV_BIT_CNTRST    1
`define PSV_BIT_HON       3
`define PSV_BIT_LON       7
`define PSV_LSB_HVOL      0
`define PSV_LSB_LVOL      4
`define PSV_BIT_ECO       0
`define PSV_BIT_REGULATOR_ON     1
`define PSV_BIT_BOOSTER_ON     2
`define PSV_BIT_BOOSTER_CLOCK_SOURCE    3
`define PSV_LSB_BOOSTER_CLOCK_DIVIDE    0
`define PSV_DIV_RST       16'h0000
`define PSV_CNT_ZERO      16'h0000
`define PSV_SYNC_RST      2'h0
`endif

// [core/psv_pkg.sv]
// Types shared by the panel supply and common clock control block
package psv_pkg;
	typedef struct packed {
		logic       highEn;
		logic [2:0] highLevel;
		logic       lowEn;
		logic [2:0] lowLevel;
	} psv_supply_s;
	typedef struct packed {
		logic       economy;
		logic       regulator_on;
		logic       boostOn;
		logic       clkSource;
		logic [2:0] clkDivide;
	} psv_booster_s;
	typedef enum logic [1:0] {
		PSV_OFF,
		PSV_RUN,
		PSV_DRAIN
	} psv_state_e;
endpackage

// [bench/psv_props.sv]
// Checker for panel supply and common clock control
`timescale 1ns/100ps
module psv_props
	import psv_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:2]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        panelCommonClock,
	input psv_supply_s      supplyCtrl
);
	logic en_ff, dis_ff, rst_ff;
	wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wr = take & wb_we_i & wb_sel_i[0];
	wire rdStat = take & ~wb_we_i & (wb_adr_i == 4'h6);
	always_ff @(posedge core_clk)
		if (sys_rst)
			{en_ff, dis_ff, rst_ff} <= 3'h0;
		else if (wr && wb_adr_i == 4'h0)
			en_ff <= wb_dat_i[0];
		else if (wr && wb_adr_i == 4'h2)
			{rst_ff, dis_ff} <= wb_dat_i[1:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence supWr;
		wr && wb_adr_i == 4'h3;
	endsequence
	AST_RST_LOW: assert property ($fell(sys_rst) |-> !panelCommonClock)
		else $error("clock high after reset");
	AST_OFF_LOW: assert property (!en_ff && !$past(en_ff) && !panelCommonClock |=> !panelCommonClock)
		else $error("clock started while off");
	AST_GATE: assert property (dis_ff && $past(dis_ff) |=> $stable(panelCommonClock))
		else $error("clock moved while gated");
	AST_CNT_RST: assert property (rdStat && rst_ff |=> wb_dat_o[15:0] == 16'h0000)
		else $error("count not held");
	AST_HI_LVL: assert property (supWr |=> supplyCtrl.highLevel == $past(wb_dat_i[2:0]))
		else $error("high level wrong");
	AST_LO_LVL: assert property (supWr |=> supplyCtrl.lowLevel == $past(wb_dat_i[6:4]))
		else $error("low level wrong");
	AST_HI_EN: assert property (supWr |=> supplyCtrl.highEn == $past(wb_dat_i[3]))
		else $error("high enable wrong");
	AST_LO_EN: assert property (supWr |=> supplyCtrl.lowEn == $past(wb_dat_i[7]))
		else $error("low enable wrong");
endmodule
bind psv_ctrl psv_props psv_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .panelCommonClock(panelCommonClock), .supplyCtrl(supplyCtrl));

// [bench/psv_panel_model.sv]
// Panel side model: free-running slow oscillator source
`timescale 1ns/100ps
module psv_panel_model
(
	input  wire logic core_clk,
	output logic      slowOscIn
);
	logic [2:0] div_ff = 3'h0;
	always_ff @(posedge core_clk)
		div_ff <= div_ff + 3'h1;
	// One rise per 8 core cycles, running before any enable
	assign slowOscIn = div_ff[2];
endmodule

// [bench/tb_top.sv]
// Testbench for panel supply and common clock control
`timescale 1ns/100ps
module tb_top;
	import psv_pkg::*;
	logic core_clk = 0, sys_rst = 1, cyc = 0, we = 0, pcc, pfp, ack, err, errSeen, osc;
	logic [5:2] adr = 4'h0;
	logic [31:0] di = 32'h0, dout, rd;
	psv_supply_s sup;
	psv_booster_s bst;
	int error_cnt = 0, samples_checked = 0, n, i, k;
	initial forever #20 core_clk = ~core_clk;
	psv_ctrl psv_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di),
		.wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err), .slowOscIn(osc),
		.panelCommonClock(pcc), .panelFramePolarity(pfp), .supplyCtrl(sup), .boosterCtrl(bst));
	psv_panel_model psv_panel_model_inst (.core_clk(core_clk), .slowOscIn(osc));
	task summarize;
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task tmo(input int c);
		if (c >= 900)
		begin
			chk(0, 1);
			summarize;
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		di <= d;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end while (!(ack | err) && k < 900);
		tmo(k);
		rd = dout;
		errSeen = err;
		cyc <= 0;
	endtask
	task half(output int h);
		k = 0;
		h = 0;
		while (pcc !== 1'b0 && k < 900)
		begin
			@(posedge core_clk);
			k++;
		end
		while (pcc !== 1'b1 && k < 900)
		begin
			@(posedge core_clk);
			k++;
		end
		while (pcc === 1'b1 && k < 900)
		begin
			@(posedge core_clk);
			k++;
			h++;
		end
		tmo(k);
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
		chk({pcc, pfp}, 0);
		chk({sup, bst}, 0);
		wb(0, 4'h7, 0);
		chk(errSeen, 1);
		for (i = 0; i < 8; i++)
		begin
			wb(1, 4'h3, {i[0], 3'(i % 7), ~i[0], 3'(i)});
			chk(sup, {~i[0], 3'(i), i[0], 3'(i % 7)});
		end
		wb(1, 4'h5, 32'hD);
		wb(1, 4'h4, 32'h6);
		chk(bst, 7'h3D);
		wb(1, 4'h4, 32'h0);
		chk(bst, 7'h0D);
		wb(1, 4'h4, 32'h1);
		chk(bst, 7'h4D);
		wb(1, 4'h4, 32'h0);
		chk(bst, 7'h0D);
		wb(1, 4'h1, 32'h2);
		wb(0, 4'h1, 0);
		chk(rd[15:0], 16'h0002);
		wb(1, 4'h0, 32'h1);
		half(n);
		chk(n, 24);
		wb(1, 4'h2, 32'h1);
		repeat (2) @(posedge core_clk);
		rd[0] = pcc;
		repeat (40) @(posedge core_clk);
		chk(pcc, rd[0]);
		wb(1, 4'h2, 32'h3);
		wb(0, 4'h6, 0);
		chk(rd[15:0], 16'h0000);
		wb(1, 4'h2, 32'h1);
		wb(1, 4'h1, 32'h0);
		wb(1, 4'h2, 32'h0);
		half(n);
		chk(n, 8);
		wb(1, 4'h0, 32'h0);
		repeat (60) @(posedge core_clk);
		chk({pcc, pfp}, 0);
		wb(1, 4'h0, 32'h1);
		repeat (40) @(posedge core_clk);
		sys_rst <= 1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		@(posedge core_clk);
		chk({pcc, pfp}, 0);
		chk({sup, bst}, 0);
		wb(0, 4'h0, 0);
		chk(rd[0], 0);
		summarize;
	end
endmodule
